// ---- serdes_status_pma_pkg.sv ----
package serdes_status_pma_pkg;

    // ------------------------------------------------------------------
    // Management device addresses and register offsets
    // ------------------------------------------------------------------
    localparam logic [4:0]  DEV_PMA        = 5'h01;
    localparam logic [4:0]  DEV_VS         = 5'h1E;
    localparam logic [15:0] ADDR_PMA_CTRL  = 16'h0000;
    localparam logic [15:0] ADDR_RES_A     = 16'h8030;
    localparam logic [15:0] ADDR_FAST_B    = 16'h8032;
    localparam logic [15:0] ADDR_FAST_C    = 16'h8033;
    localparam logic [15:0] ADDR_SLOW      = 16'h8034;
    localparam logic [15:0] ADDR_RES_STAT  = 16'h8035;
    localparam logic [15:0] ADDR_RES_B     = 16'h8100;
    localparam logic [15:0] ADDR_RES_C     = 16'h8101;
    localparam logic [15:0] ADDR_DBG       = 16'h9000;

    // ------------------------------------------------------------------
    // Reset values, writable masks and field positions
    // ------------------------------------------------------------------
    localparam logic [15:0] REG_RESET      = 16'h0000;
    localparam logic [15:0] MASK_RES_A     = 16'h000F;
    localparam logic [15:0] MASK_RES_B     = 16'h07FF;
    localparam logic [15:0] MASK_RES_C     = 16'h3FFF;
    localparam logic [15:0] MASK_DBG       = 16'h0F31;
    localparam int          CTRL_RST_BIT   = 15;
    localparam int          CTRL_LPWR_BIT  = 11;
    localparam int          CTRL_LOOP_BIT  = 0;
    localparam int          FB_RXEN_BIT    = 11;
    localparam int          FB_TRACK_BIT   = 10;
    localparam int          FB_EQHLD_BIT   = 9;
    localparam int          FB_CRF_LSB     = 4;
    localparam int          FB_SWING_LSB   = 0;
    localparam int          FC_TXRATE_LSB  = 8;
    localparam int          FC_RXRATE_LSB  = 4;
    localparam int          FC_PLL_LSB     = 0;
    localparam int          SL_TXRATE_LSB  = 8;
    localparam int          SL_RXRATE_LSB  = 4;
    localparam int          SL_PLL_LSB     = 0;

    // ------------------------------------------------------------------
    // Frame layout, opcodes and timing
    // ------------------------------------------------------------------
    localparam logic [1:0]  OP_ADDR        = 2'h0;
    localparam logic [1:0]  OP_WRITE       = 2'h1;
    localparam logic [1:0]  OP_READINC     = 2'h2;
    localparam logic [1:0]  OP_READ        = 2'h3;
    localparam logic [5:0]  PREAMBLE_ONES  = 6'h20;
    localparam logic [5:0]  HDR_LAST       = 6'h0D;
    localparam logic [5:0]  TA_DRIVE       = 6'h0F;
    localparam logic [5:0]  FRAME_LAST     = 6'h1F;
    localparam int          SOFT_RST_NS    = 100;
    localparam int          CLK_PERIOD_NS  = 10;
    localparam logic [7:0]  SOFT_RST_COUNT =
        8'((SOFT_RST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    typedef enum logic [0:0] {
        ST_PREAMBLE = 1'b0,
        ST_FRAME    = 1'b1
    } mdio_state_e;

endpackage

// ---- serdes_status_pma_control_regs.sv ----
`timescale 1ns/1ps
// Function
// - Fast status B: rx enable, track, hold.
// - Fast status B: cursor reduction, swing fields.
// - Fast status C: tx, rx rate, multiplier.
// - Slow status: tx, rx rate, multiplier.
// - One debug register shared by every channel.
// - Answer only device addresses one and vendor.
// - Control bit 15 resets every control register, self clears.
// - Control bit 11 requests low power.
// - Control bit 0 enables fast serial loopback.
module serdes_status_pma_control_regs
    import serdes_status_pma_pkg::*;
#(
    parameter logic [4:0] PORT_ADDR = 5'h00, // Base port address
    parameter logic [4:0] PORT_MASK = 5'h1C  // Port bits that must match
) (
    input  wire logic       mclk,                        // Management clock
    input  wire logic       rst,                         // Async reset
    input  wire logic       mdc,                         // Management clock pin
    input  wire logic       mdioIn,                      // Data pin level
    output logic            mdioOut,                     // Data pin drive
    output logic            mdioOeN,                     // Drive enable, low
    input  wire logic       fast_final_rx_enable,        // Fast rx enable
    input  wire logic       fast_final_track_enable,     // Fast tracking
    input  wire logic       fast_final_equalizer_hold,   // Fast eq hold
    input  wire logic [4:0] fast_final_cursor_reduction, // Cursor weights
    input  wire logic [3:0] fast_final_swing,            // Fast swing
    input  wire logic [1:0] fast_final_tx_rate,          // Fast tx rate
    input  wire logic [2:0] fast_final_rx_rate,          // Fast rx rate
    input  wire logic [3:0] final_pll_multiplier,        // Fast PLL mult
    input  wire logic [1:0] slow_final_tx_rate,          // Slow tx rate
    input  wire logic [1:0] slow_final_rx_rate,          // Slow rx rate
    input  wire logic [3:0] slow_final_pll_multiplier,   // Slow PLL mult
    output logic            low_power_request,           // Power down
    output logic            serialLoopback,              // Fast loopback
    output logic            datapathReset,               // Global reset
    output logic [15:0]     reservedCtrlA,               // Spare control
    output logic [15:0]     reservedCtrlB,               // Spare control
    output logic [15:0]     reservedCtrlC,               // Spare control
    output logic [15:0]     debugCtrl                    // Shared debug
);
    import serdes_status_pma_pkg::*;

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    logic [1:0]  mdcSync;
    logic [1:0]  mdioSync;
    logic        mdcPrev;
    logic [47:0] statMeta;
    logic [47:0] statSync;
    logic [47:0] statImg;
    logic        mdcRise;
    logic        mdcFall;
    logic        bitIn;
    logic [13:0] hdr;
    logic        hdrHit;
    logic        hdrVs;
    logic [15:0] rdWord;
    logic [15:0] pmaWord;
    logic [15:0] wData;
    logic        wrPma;
    logic        wrDbg;
    logic        busy;
    mdio_state_e state_q,   state_d;
    logic [5:0]  ones_q,    ones_d;
    logic [5:0]  cnt_q,     cnt_d;
    logic [15:0] shift_q,   shift_d;
    logic [1:0]  op_q,      op_d;
    logic        hit_q,     hit_d;
    logic        devVs_q,   devVs_d;
    logic [15:0] rdData_q,  rdData_d;
    logic        mdioOut_q, mdioOut_d;
    logic        oeN_q,     oeN_d;
    logic [15:0] addrPma_q, addrPma_d;
    logic [15:0] addrVs_q,  addrVs_d;
    logic        lowPwr_q,  lowPwr_d;
    logic        loop_q,    loop_d;
    logic [15:0] resA_q,    resA_d;
    logic [15:0] resB_q,    resB_d;
    logic [15:0] resC_q,    resC_d;
    logic [15:0] dbg_q,     dbg_d;
    logic [7:0]  soft_q,    soft_d;

    // ------------------------------------------------------------------
    // Input synchronisers and status images
    // ------------------------------------------------------------------
    // Status fields come from serializer clocks, so each bit passes two
    // flops; a multi-bit field may show a mix for one cycle while moving.
    always_comb begin
        statImg = '0;
        statImg[FB_RXEN_BIT]            = fast_final_rx_enable;
        statImg[FB_TRACK_BIT]           = fast_final_track_enable;
        statImg[FB_EQHLD_BIT]           = fast_final_equalizer_hold;
        statImg[FB_CRF_LSB +: 5]        = fast_final_cursor_reduction;
        statImg[FB_SWING_LSB +: 4]      = fast_final_swing;
        statImg[16 + FC_TXRATE_LSB +: 2] = fast_final_tx_rate;
        statImg[16 + FC_RXRATE_LSB +: 3] = fast_final_rx_rate;
        statImg[16 + FC_PLL_LSB +: 4]   = final_pll_multiplier;
        statImg[32 + SL_TXRATE_LSB +: 2] = slow_final_tx_rate;
        statImg[32 + SL_RXRATE_LSB +: 2] = slow_final_rx_rate;
        statImg[32 + SL_PLL_LSB +: 4]   = slow_final_pll_multiplier;
    end

    assign mdcRise = mdcSync[1] & ~mdcPrev;
    assign mdcFall = ~mdcSync[1] & mdcPrev;
    assign bitIn   = mdioSync[1];
    assign hdr     = {shift_q[12:0], bitIn};
    assign hdrVs   = (hdr[4:0] == DEV_VS);
    // Clause 45 start, port group match and one of our two devices.
    assign hdrHit  = ~hdr[12] & ((hdr[9:5] & PORT_MASK) == PORT_ADDR)
                   & ((hdr[4:0] == DEV_PMA) | hdrVs);
    assign busy    = (soft_q != 8'h00);
    assign pmaWord = {busy, 3'h0, lowPwr_q, 10'h000, loop_q};

    // ------------------------------------------------------------------
    // Read decode
    // ------------------------------------------------------------------
    always_comb begin
        rdWord = REG_RESET;
        if (!hdrVs) begin
            if (addrPma_q == ADDR_PMA_CTRL) begin
                rdWord = pmaWord;
            end
        end else begin
            case (addrVs_q)
                ADDR_RES_A:    rdWord = resA_q;
                ADDR_FAST_B:   rdWord = statSync[15:0];
                ADDR_FAST_C:   rdWord = statSync[31:16];
                ADDR_SLOW:     rdWord = statSync[47:32];
                ADDR_RES_STAT: rdWord = REG_RESET;
                ADDR_RES_B:    rdWord = resB_q;
                ADDR_RES_C:    rdWord = resC_q;
                ADDR_DBG:      rdWord = dbg_q;
                default:       rdWord = REG_RESET;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Frame engine and register file, next state
    // ------------------------------------------------------------------
    always_comb begin
        state_d   = state_q;
        ones_d    = ones_q;
        cnt_d     = cnt_q;
        shift_d   = shift_q;
        op_d      = op_q;
        hit_d     = hit_q;
        devVs_d   = devVs_q;
        rdData_d  = rdData_q;
        mdioOut_d = mdioOut_q;
        oeN_d     = oeN_q;
        addrPma_d = addrPma_q;
        addrVs_d  = addrVs_q;
        lowPwr_d  = lowPwr_q;
        loop_d    = loop_q;
        resA_d    = resA_q;
        resB_d    = resB_q;
        resC_d    = resC_q;
        dbg_d     = dbg_q;
        soft_d    = busy ? soft_q - 8'h01 : soft_q;
        wData     = {shift_q[14:0], bitIn};
        wrPma     = 1'b0;
        wrDbg     = 1'b0;
        if (mdcRise) begin
            case (state_q)
                ST_PREAMBLE: begin
                    if (bitIn) begin
                        ones_d = (ones_q == PREAMBLE_ONES) ? ones_q
                                                           : ones_q + 6'h01;
                    end else begin
                        ones_d = 6'h00;
                        if (ones_q == PREAMBLE_ONES) begin
                            state_d = ST_FRAME;
                            cnt_d   = 6'h01;
                            shift_d = 16'h0000;
                        end
                    end
                end
                ST_FRAME: begin
                    shift_d = wData;
                    cnt_d   = cnt_q + 6'h01;
                    if (cnt_q == HDR_LAST) begin
                        hit_d    = hdrHit;
                        op_d     = hdr[11:10];
                        devVs_d  = hdrVs;
                        rdData_d = rdWord;
                        if (hdrHit && hdr[11:10] == OP_READINC) begin
                            if (hdrVs) begin
                                addrVs_d = addrVs_q + 16'h0001;
                            end else begin
                                addrPma_d = addrPma_q + 16'h0001;
                            end
                        end
                    end
                    if (cnt_q == FRAME_LAST) begin
                        state_d = ST_PREAMBLE;
                        if (hit_q && op_q == OP_ADDR) begin
                            if (devVs_q) begin
                                addrVs_d = wData;
                            end else begin
                                addrPma_d = wData;
                            end
                        end
                        if (hit_q && op_q == OP_WRITE) begin
                            wrPma = !devVs_q && addrPma_q == ADDR_PMA_CTRL;
                            wrDbg = devVs_q && addrVs_q == ADDR_DBG;
                            if (wrPma) begin
                                lowPwr_d = wData[CTRL_LPWR_BIT];
                                loop_d   = wData[CTRL_LOOP_BIT];
                                if (wData[CTRL_RST_BIT] && !busy) begin
                                    soft_d = SOFT_RST_COUNT;
                                end
                            end
                            if (devVs_q) begin
                                case (addrVs_q)
                                    ADDR_RES_A: resA_d = wData & MASK_RES_A;
                                    ADDR_RES_B: resB_d = wData & MASK_RES_B;
                                    ADDR_RES_C: resC_d = wData & MASK_RES_C;
                                    ADDR_DBG:   dbg_d  = wData & MASK_DBG;
                                    default:    resA_d = resA_q;
                                endcase
                            end
                        end
                    end
                end
                default: state_d = ST_PREAMBLE;
            endcase
        end
        // Read data turns round on the clock's low phase, giving the host
        // half a period less three mclk cycles (two synchroniser flops and the output flop) of setup before it samples on the rise.
        if (mdcFall) begin
            if (state_q == ST_FRAME && hit_q && op_q[1]
                && cnt_q >= TA_DRIVE) begin
                oeN_d     = 1'b0;
                mdioOut_d = (cnt_q == TA_DRIVE)
                          ? 1'b0 : rdData_q[4'(FRAME_LAST - cnt_q)];
            end else begin
                oeN_d     = 1'b1;
                mdioOut_d = 1'b1;
            end
        end
        // The global reset holds every management register at default,
        // so a write landing inside the reset window is dropped.
        if (busy) begin
            addrPma_d = REG_RESET;
            addrVs_d  = REG_RESET;
            lowPwr_d  = 1'b0;
            loop_d    = 1'b0;
            resA_d    = REG_RESET;
            resB_d    = REG_RESET;
            resC_d    = REG_RESET;
            dbg_d     = REG_RESET;
        end
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            mdcSync   <= 2'h0;
            mdioSync  <= 2'h3;
            mdcPrev   <= 1'b0;
            statMeta  <= 48'h0;
            statSync  <= 48'h0;
            state_q   <= ST_PREAMBLE;
            ones_q    <= 6'h00;
            cnt_q     <= 6'h00;
            shift_q   <= 16'h0000;
            op_q      <= OP_ADDR;
            hit_q     <= 1'b0;
            devVs_q   <= 1'b0;
            rdData_q  <= 16'h0000;
            mdioOut_q <= 1'b1;
            oeN_q     <= 1'b1;
            addrPma_q <= REG_RESET;
            addrVs_q  <= REG_RESET;
            lowPwr_q  <= 1'b0;
            loop_q    <= 1'b0;
            resA_q    <= REG_RESET;
            resB_q    <= REG_RESET;
            resC_q    <= REG_RESET;
            dbg_q     <= REG_RESET;
            soft_q    <= 8'h00;
        end else begin
            mdcSync   <= {mdcSync[0], mdc};
            mdioSync  <= {mdioSync[0], mdioIn};
            mdcPrev   <= mdcSync[1];
            statMeta  <= statImg;
            statSync  <= statMeta;
            state_q   <= state_d;
            ones_q    <= ones_d;
            cnt_q     <= cnt_d;
            shift_q   <= shift_d;
            op_q      <= op_d;
            hit_q     <= hit_d;
            devVs_q   <= devVs_d;
            rdData_q  <= rdData_d;
            mdioOut_q <= mdioOut_d;
            oeN_q     <= oeN_d;
            addrPma_q <= addrPma_d;
            addrVs_q  <= addrVs_d;
            lowPwr_q  <= lowPwr_d;
            loop_q    <= loop_d;
            resA_q    <= resA_d;
            resB_q    <= resB_d;
            resC_q    <= resC_d;
            dbg_q     <= dbg_d;
            soft_q    <= soft_d;
        end
    end

    assign mdioOut           = mdioOut_q;
    assign mdioOeN           = oeN_q;
    assign low_power_request = lowPwr_q;
    assign serialLoopback    = loop_q;
    assign datapathReset     = busy;
    assign reservedCtrlA     = resA_q;
    assign reservedCtrlB     = resB_q;
    assign reservedCtrlC     = resC_q;
    assign debugCtrl         = dbg_q;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    sequence s_rstWrite;
        wrPma && !busy && wData[CTRL_RST_BIT];
    endsequence
    sequence s_rstWindow;
        datapathReset [*8] ##1 datapathReset [*2] ##1 !datapathReset;
    endsequence
    property p_softReset;
        @(posedge mclk) disable iff (rst) s_rstWrite |=> s_rstWindow;
    endproperty
    a_softReset: assert property (p_softReset)
        else $error("Global reset did not last ten cycles.");
    property p_rstReadsOne;
        @(posedge mclk) disable iff (rst)
        datapathReset && !hdrVs && addrPma_q == ADDR_PMA_CTRL
            |-> rdWord[CTRL_RST_BIT];
    endproperty
    a_rstReadsOne: assert property (p_rstReadsOne)
        else $error("Reset bit read zero during reset.");
    property p_defaults;
        @(posedge mclk) disable iff (rst)
        $fell(datapathReset) |-> !low_power_request && !serialLoopback
            && debugCtrl == REG_RESET && !pmaWord[CTRL_RST_BIT];
    endproperty
    a_defaults: assert property (p_defaults)
        else $error("Registers not at default after reset.");
    property p_lowPower;
        @(posedge mclk) disable iff (rst)
        wrPma && !busy |=> low_power_request == $past(wData[CTRL_LPWR_BIT]);
    endproperty
    a_lowPower: assert property (p_lowPower)
        else $error("Power down request did not follow write.");
    property p_loopback;
        @(posedge mclk) disable iff (rst)
        $rose(serialLoopback) |-> $past(wrPma) && $past(wData[CTRL_LOOP_BIT]);
    endproperty
    a_loopback: assert property (p_loopback)
        else $error("Loopback rose without a control write.");
    property p_debug;
        @(posedge mclk) disable iff (rst)
        wrDbg && !busy |=> debugCtrl == ($past(wData) & MASK_DBG);
    endproperty
    a_debug: assert property (p_debug)
        else $error("Shared debug register missed a write.");
    property p_devAddr;
        @(posedge mclk) disable iff (rst)
        mdcRise && state_q == ST_FRAME && cnt_q == HDR_LAST
            && hdr[4:0] != DEV_PMA && !hdrVs |=> !hit_q ##1 mdioOeN;
    endproperty
    a_devAddr: assert property (p_devAddr)
        else $error("Answered a foreign device address.");
    property p_fastB;
        @(posedge mclk) disable iff (rst)
        ##2 statSync[15:0] == $past(statImg[15:0], 2);
    endproperty
    a_fastB: assert property (p_fastB)
        else $error("Fast status B does not track its inputs.");
    property p_fastBFields;
        @(posedge mclk) disable iff (rst)
        ##2 statSync[8:0] == $past({fast_final_cursor_reduction,
                                    fast_final_swing}, 2);
    endproperty
    a_fastBFields: assert property (p_fastBFields)
        else $error("Cursor or swing field misplaced.");
    property p_fastC;
        @(posedge mclk) disable iff (rst)
        ##2 statSync[25:16] == $past({fast_final_tx_rate, 1'b0,
            fast_final_rx_rate, final_pll_multiplier}, 2);
    endproperty
    a_fastC: assert property (p_fastC)
        else $error("Fast status C fields misplaced.");
    property p_slow;
        @(posedge mclk) disable iff (rst)
        ##2 statSync[41:32] == $past({slow_final_tx_rate, 2'h0,
            slow_final_rx_rate, slow_final_pll_multiplier}, 2);
    endproperty
    a_slow: assert property (p_slow)
        else $error("Slow status fields misplaced.");

endmodule

// ---- mdio_host_model.sv ----
`timescale 1ns/1ps
// Station host: the clock stands low between frames, and a released data
// pin floats to the pull-up that the bench resolves.
module mdio_host_model (
    input  wire logic   mclk,    // Timing reference
    input  wire logic   mdio,    // Resolved data wire
    output logic        mdc,     // Management clock pin
    output logic        hostOut, // Host data drive
    output logic        hostOeN, // Host drive enable, low
    output logic [15:0] rdData,  // Last word read
    output logic        rdValid  // Word ready, one cycle
);
    initial begin
        mdc = 1'b0;
        hostOut = 1'b1;
        hostOeN = 1'b1;
        rdData = 16'h0000;
        rdValid = 1'b0;
    end

    // One 100 ns bit; slow enough for the two-flop pin synchronisers.
    task automatic cyc(input logic oeN, b, output logic s);
        hostOeN = oeN;
        hostOut = oeN ? 1'b1 : b;
        repeat (5) @(negedge mclk);
        mdc = 1'b1;
        s = mdio;
        repeat (5) @(negedge mclk);
        mdc = 1'b0;
    endtask

    // Whole frame with its own preamble; reads release from turnaround.
    task automatic frame(input logic [4:0] p, d, input logic [1:0] op,
                         input logic [15:0] v);
        logic [63:0] f;
        logic [15:0] w;
        logic        s;
        f = {32'hFFFF_FFFF, 2'b00, op, p, d, 2'b10, v};
        w = 16'h0000;
        for (int i = 63; i >= 0; i--) begin
            cyc(op[1] && i < 18, f[i], s);
            if (i < 16) w[i] = s;
        end
        hostOeN = 1'b1;
        if (op[1]) begin
            rdData = w;
            rdValid = 1'b1;
            @(negedge mclk);
            rdValid = 1'b0;
        end
    endtask
endmodule

// ---- serdes_status_pma_control_regs_bench.sv ----
`timescale 1ns/1ps
`define CHK(n, e, s) begin nTests++; if ((s) !== (e)) begin badCount++; \
    $display("wrong value %s exp %h got %h", n, e, s); end end
module serdes_status_pma_control_regs_bench;
    import serdes_status_pma_pkg::*;
    logic        mclk, rst, mdc, hostOut, hostOeN, mdioOut, mdioOeN;
    logic        rdValid, lowPwr, loopEn, dpRst;
    logic [15:0] rdData, resA, resB, resC, dbg, wrv, expW;
    logic [28:0] st;
    logic [15:0] expQ[$];
    logic [15:0] regs[9] = '{ADDR_RES_A, 16'h8031, ADDR_FAST_B, ADDR_FAST_C,
        ADDR_SLOW, ADDR_RES_STAT, ADDR_RES_B, ADDR_RES_C, ADDR_DBG};
    int          badCount, nTests, rstLen;
    wire mdio = !mdioOeN ? mdioOut : (!hostOeN ? hostOut : 1'b1);

    serdes_status_pma_control_regs dut_u (
        .mclk(mclk), .rst(rst), .mdc(mdc), .mdioIn(mdio),
        .mdioOut(mdioOut), .mdioOeN(mdioOeN),
        .fast_final_rx_enable(st[28]), .fast_final_track_enable(st[27]),
        .fast_final_equalizer_hold(st[26]),
        .fast_final_cursor_reduction(st[25:21]),
        .fast_final_swing(st[20:17]), .fast_final_tx_rate(st[16:15]),
        .fast_final_rx_rate(st[14:12]), .final_pll_multiplier(st[11:8]),
        .slow_final_tx_rate(st[7:6]), .slow_final_rx_rate(st[5:4]),
        .slow_final_pll_multiplier(st[3:0]), .low_power_request(lowPwr),
        .serialLoopback(loopEn), .datapathReset(dpRst),
        .reservedCtrlA(resA), .reservedCtrlB(resB),
        .reservedCtrlC(resC), .debugCtrl(dbg));
    mdio_host_model host_u (.mclk(mclk), .mdio(mdio), .mdc(mdc),
        .hostOut(hostOut), .hostOeN(hostOeN), .rdData(rdData),
        .rdValid(rdValid));

    // Expected read word; spares keep only their writable bits.
    function automatic logic [15:0] model(input logic [15:0] a);
        case (a)
            ADDR_RES_A:  return MASK_RES_A & wrv;
            ADDR_RES_B:  return MASK_RES_B & wrv;
            ADDR_RES_C:  return MASK_RES_C & wrv;
            ADDR_DBG:    return MASK_DBG & wrv;
            ADDR_FAST_B: return {4'h0, st[28:17]};
            ADDR_FAST_C: return {6'h00, st[16:15], 1'b0, st[14:8]};
            ADDR_SLOW:   return {6'h00, st[7:6], 2'b00, st[5:0]};
            default:     return 16'h0000;
        endcase
    endfunction

    task automatic wr(input logic [4:0] p, d, input logic [15:0] a, v);
        host_u.frame(p, d, OP_ADDR, a);
        host_u.frame(p, d, OP_WRITE, v);
    endtask

    // The note goes on the queue before the frame that will answer it.
    task automatic rd(input logic [4:0] p, d, input logic [15:0] a, e);
        expQ.push_back(e);
        host_u.frame(p, d, OP_ADDR, a);
        host_u.frame(p, d, OP_READ, 16'h0000);
    endtask

    // Each register read in turn, channel address cycling through 0 to 3.
    task automatic sweep();
        foreach (regs[i])
            rd(5'(i % 4), DEV_VS, regs[i], model(regs[i]));
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", nTests, badCount);
        if (badCount == 0 && nTests > 0 && expQ.size() == 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    // Watcher: every word the host reads is matched to the oldest note.
    always @(posedge mclk) begin
        if (dpRst === 1'b1) rstLen++;
        if (rdValid === 1'b1) begin
            expW = (expQ.size() > 0) ? expQ.pop_front() : 16'hXXXX;
            `CHK("read word", expW, rdData)
        end
    end

    // Watchdog: a hung frame counts as a mismatch.
    initial begin
        #1_000_000;
        badCount++;
        results();
    end

    // --------------------------------------------------------------
    // Main sequence
    // --------------------------------------------------------------
    initial begin
        rst = 1'b1;
        st = '0;
        wrv = 16'h0000;
        void'($urandom(56702));
        repeat (2) @(posedge mclk);
        @(negedge mclk) rst = 1'b0;
        repeat (3) @(negedge mclk);
        sweep();
        $display("test reset values done");
        st = 29'($urandom());
        wrv = 16'hFFFF;
        foreach (regs[i]) wr(5'((i + 2) % 4), DEV_VS, regs[i], wrv);
        sweep();
        `CHK("debug pins", MASK_DBG, dbg)
        `CHK("spare pins", MASK_RES_C, resC)
        `CHK("spare a pins", MASK_RES_A, resA)
        `CHK("spare b pins", MASK_RES_B, resB)
        // Read-increment walks from one spare to the next.
        expQ.push_back(MASK_RES_B);
        expQ.push_back(MASK_RES_C);
        host_u.frame(5'h03, DEV_VS, OP_ADDR, ADDR_RES_B);
        repeat (2) host_u.frame(5'h03, DEV_VS, OP_READINC, 16'h0000);
        $display("test status and spares done");
        wr(5'h00, 5'h03, ADDR_PMA_CTRL, 16'h0801);
        `CHK("loop wrong dev", 1'b0, loopEn)
        wr(5'h01, DEV_PMA, ADDR_PMA_CTRL, 16'h0801);
        `CHK("low power", 1'b1, lowPwr)
        `CHK("loopback", 1'b1, loopEn)
        rd(5'h02, DEV_PMA, ADDR_PMA_CTRL, 16'h0801);
        $display("test control done");
        rstLen = 0;
        wr(5'h00, DEV_PMA, ADDR_PMA_CTRL, 16'h8801);
        repeat (20) @(negedge mclk);
        `CHK("reset length", 10, rstLen)
        `CHK("loop after reset", 1'b0, loopEn)
        `CHK("power after reset", 1'b0, lowPwr)
        `CHK("debug after reset", 16'h0000, dbg)
        wrv = 16'h0000;
        rd(5'h00, DEV_PMA, ADDR_PMA_CTRL, 16'h0000);
        sweep();
        $display("test soft reset done");
        results();
    end
endmodule
